// *** design/lpchi_pkg.sv ***
// Purpose: shared constants and types for the two-channel memory pin block
// Assumes: one command per channel in flight across the link crossing
// Notes: widths follow the pin groups of each channel
package lpchi_pkg;
	localparam int DQ_W = 64;
	localparam int DQS_W = 8;
	localparam int CA_W = 10;
	localparam int CK_W = 2;
	localparam int RANK_W = 2;
	localparam int CKE_W = 4;
	localparam int BUF_N = 2;
	localparam logic [1:0] BUF_FULL = 2'h2;
	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam int RD_WAIT_CYC = 16;
	localparam logic [4:0] RD_WAIT = 5'(RD_WAIT_CYC);
	localparam logic [RANK_W-1:0] RANKS_IDLE = 2'h3;
	localparam logic [CKE_W-1:0] CKE_OFF = 4'h0;
	localparam logic [DQS_W-1:0] STRB_HI = 8'hff;
	localparam logic [DQS_W-1:0] STRB_LO = 8'h00;

	typedef enum logic [1:0] {OP_NOP, OP_WRITE, OP_READ} lpchi_op_t;

	typedef struct packed {
		lpchi_op_t op;
		logic [RANK_W-1:0] rank_sel_n;
		logic [CA_W-1:0] ca_first;
		logic [CA_W-1:0] ca_second;
		logic [RANK_W-1:0] rank_cke;
		logic odt;
		logic [DQ_W-1:0] wdata;
	} lpchi_cmd_t;

	typedef struct packed {
		logic timeout;
		logic [DQ_W-1:0] data;
	} lpchi_rd_t;

	typedef enum logic [2:0] {L_IDLE, L_WR0, L_WR1, L_RD, L_DONE} lpchi_st_t;
endpackage

// *** design/lpchi_top.sv ***
// Purpose: pin side of two memory-down channels toward soldered sdram
// Assumes: link clock drives the pin logic; the memory clock is divided
// Assumes: from it by two; core clock runs the command buffer
// Notes: one command in flight per channel; reads answer with data
// Behaviour
// RULE_01 - Two separate channels each carry a 64-bit two-way data bus.
// RULE_02 - Each channel has eight strobe pairs and data counts at their crossing.
// RULE_03 - Each channel drives two 10-bit command and address buses.
// RULE_04 - Each channel drives two memory clock pairs, sampled at true rising.
// RULE_05 - One active-low select per rank, two ranks, picks who responds.
// RULE_06 - Four clock enables serve init, rank power-down and self-refresh.
// RULE_07 - Single rank drives enables 0 and 2 together for rank 0.
// RULE_08 - Dual rank uses enables 0 and 2 for rank 0, 1 and 3 for rank 1.
// RULE_09 - Each channel drives one termination control output.
// RULE_10 - Data and strobes are driven only in writes and released in reads.
`timescale 1ns/1ps

module lpchi_chan (
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // async reset, low
	input wire logic link_clk_i, // pin side clock
	input wire logic dual_rank_i, // two ranks fitted
	input wire logic suspend_to_ram_i, // hold ranks in self-refresh
	input wire lpchi_pkg::lpchi_cmd_t cmd_i, // command word
	input wire logic cmd_valid_i, // command offered
	output logic cmd_ready_o, // buffer has room
	output lpchi_pkg::lpchi_rd_t rd_o, // read answer
	output logic rd_valid_o, // read answer pulse
	input wire logic [lpchi_pkg::DQ_W-1:0] dq_i, // data pins in
	output logic [lpchi_pkg::DQ_W-1:0] dq_o, // data pins out
	output logic dq_oe_o, // data drive enable
	input wire logic [lpchi_pkg::DQS_W-1:0] dqs_t_i, // strobe true in
	input wire logic [lpchi_pkg::DQS_W-1:0] dqs_c_i, // strobe comp in
	output logic [lpchi_pkg::DQS_W-1:0] dqs_t_o, // strobe true out
	output logic [lpchi_pkg::DQS_W-1:0] dqs_c_o, // strobe comp out
	output logic dqs_oe_o, // strobe drive enable
	output logic [lpchi_pkg::CA_W-1:0] ca_first_o, // first cmd/addr bus
	output logic [lpchi_pkg::CA_W-1:0] ca_second_o, // second cmd/addr bus
	output logic [lpchi_pkg::CK_W-1:0] ck_t_o, // memory clock true
	output logic [lpchi_pkg::CK_W-1:0] ck_c_o, // memory clock comp
	output logic [lpchi_pkg::RANK_W-1:0] cs_n_o, // rank selects, low
	output logic [lpchi_pkg::CKE_W-1:0] cke_o, // clock enables
	output logic odt_o // termination control
);
	import lpchi_pkg::*;

	// core domain: two-entry buffer and request handshake
	lpchi_cmd_t buf_q [BUF_N];
	lpchi_cmd_t hold_q;
	lpchi_rd_t rd_q;
	lpchi_rd_t rd_hold_q;
	logic wp_q, rp_q, busy_q, req_q, rd_valid_q;
	logic ack_s1_q, ack_s2_q, ack_seen_q, ack_q;
	logic [1:0] cnt_q;

	wire logic push = cmd_valid_i && cmd_ready_o;
	wire logic pop = (cnt_q != BUF_EMPTY) && !busy_q;
	wire logic ack_evt = ack_s2_q ^ ack_seen_q;
	wire logic [1:0] cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});

	assign cmd_ready_o = (cnt_q != BUF_FULL);
	assign rd_o = rd_q;
	assign rd_valid_o = rd_valid_q;

	always_ff @(posedge clk_i) begin
		if (push) begin
			buf_q[wp_q] <= cmd_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_q <= 1'h0;
			rp_q <= 1'h0;
			cnt_q <= BUF_EMPTY;
			busy_q <= 1'h0;
			req_q <= 1'h0;
			hold_q <= '0;
			ack_s1_q <= 1'h0;
			ack_s2_q <= 1'h0;
			ack_seen_q <= 1'h0;
			rd_q <= '0;
			rd_valid_q <= 1'h0;
		end else begin
			cnt_q <= cnt_d;
			wp_q <= wp_q ^ push;
			rp_q <= rp_q ^ pop;
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
			ack_seen_q <= ack_s2_q;
			rd_valid_q <= ack_evt && (hold_q.op == OP_READ);
			if (pop) begin
				hold_q <= buf_q[rp_q];
				req_q <= ~req_q;
				busy_q <= 1'h1;
			end else if (ack_evt) begin
				busy_q <= 1'h0;
			end
			// link holds its answer until the next read finishes
			if (ack_evt && hold_q.op == OP_READ) begin
				rd_q <= rd_hold_q;
			end
		end
	end

	// link domain
	lpchi_st_t st_q, st_d;
	lpchi_cmd_t cur_q;
	logic lr1_q, lrst_n;
	logic req_s1_q, req_s2_q, req_seen_q;
	logic dual_s1_q, dual_s2_q, susp_s1_q, susp_s2_q;
	logic [DQ_W-1:0] dq_s1_q, dq_s2_q, dq_o_q;
	logic [DQS_W-1:0] str_s1_q, str_s2_q, str_s3_q, cmp_s1_q, cmp_s2_q;
	logic [DQS_W-1:0] dqs_t_q, dqs_c_q;
	logic ck_q, ckn_q, odt_q, dq_oe_q, dqs_oe_q;
	logic [4:0] wt_q;
	logic [CA_W-1:0] ca1_q, ca2_q;
	logic [RANK_W-1:0] cs_q;
	logic [CKE_W-1:0] cke_q;

	wire logic new_req = req_s2_q ^ req_seen_q;
	// change pins as the memory clock falls so they settle for its rise
	wire logic take = (st_q == L_IDLE) && new_req && ck_q;
	wire logic xing = (&str_s2_q) && !(|cmp_s2_q) && !(&str_s3_q);
	wire logic rd_out = (wt_q == RD_WAIT);
	wire logic wr_d = (st_d == L_WR0) || (st_d == L_WR1);
	wire logic [DQS_W-1:0] dqs_t_d = (st_d == L_WR1) ? STRB_HI : STRB_LO;
	wire logic r1_on = dual_s2_q && cur_q.rank_cke[1];
	wire logic r0_on = cur_q.rank_cke[0];
	wire logic [CKE_W-1:0] cke_d = susp_s2_q ? CKE_OFF :
		{r1_on, r0_on, r1_on, r0_on}; // RULE_06 RULE_07 RULE_08

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			L_IDLE: begin
				if (take) begin
					st_d = (hold_q.op == OP_WRITE) ? L_WR0 :
						(hold_q.op == OP_READ) ? L_RD : L_DONE;
				end
			end
			L_WR0: begin
				if (ck_q) begin
					st_d = L_WR1;
				end
			end
			L_WR1: begin
				if (ck_q) begin
					st_d = L_DONE;
				end
			end
			L_RD: begin
				if (xing || rd_out) begin
					st_d = L_DONE; // RULE_02
				end
			end
			L_DONE: begin
				st_d = L_IDLE;
			end
		endcase
	end

	// reset asserts at once, releases on the link clock
	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lr1_q <= 1'h0;
			lrst_n <= 1'h0;
		end else begin
			lr1_q <= 1'h1;
			lrst_n <= lr1_q;
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			req_s1_q <= 1'h0;
			req_s2_q <= 1'h0;
			dual_s1_q <= 1'h0;
			dual_s2_q <= 1'h0;
			susp_s1_q <= 1'h0;
			susp_s2_q <= 1'h0;
			dq_s1_q <= '0;
			dq_s2_q <= '0;
			str_s1_q <= STRB_LO;
			str_s2_q <= STRB_LO;
			str_s3_q <= STRB_LO;
			cmp_s1_q <= STRB_LO;
			cmp_s2_q <= STRB_LO;
		end else begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			dual_s1_q <= dual_rank_i;
			dual_s2_q <= dual_s1_q;
			susp_s1_q <= suspend_to_ram_i;
			susp_s2_q <= susp_s1_q;
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
			str_s1_q <= dqs_t_i;
			str_s2_q <= str_s1_q;
			str_s3_q <= str_s2_q;
			cmp_s1_q <= dqs_c_i;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			st_q <= L_IDLE;
			ck_q <= 1'h0;
			ckn_q <= 1'h1;
			wt_q <= 5'h00;
			ack_q <= 1'h0;
			cke_q <= CKE_OFF;
			dq_oe_q <= 1'h0;
			dqs_oe_q <= 1'h0;
			dqs_t_q <= STRB_LO;
			dqs_c_q <= STRB_HI;
		end else begin
			st_q <= st_d;
			ck_q <= ~ck_q; // RULE_04
			ckn_q <= ck_q; // RULE_04
			wt_q <= (st_q == L_RD) ? 5'(wt_q + 5'h01) : 5'h00;
			ack_q <= ack_q ^ (st_q == L_DONE);
			cke_q <= cke_d; // RULE_06
			dq_oe_q <= wr_d; // RULE_10
			dqs_oe_q <= wr_d; // RULE_10
			dqs_t_q <= dqs_t_d; // RULE_02
			dqs_c_q <= ~dqs_t_d; // RULE_02
		end
	end

	always_ff @(posedge link_clk_i or negedge lrst_n) begin
		if (!lrst_n) begin
			req_seen_q <= 1'h0;
			cur_q <= '0;
			ca1_q <= '0;
			ca2_q <= '0;
			cs_q <= RANKS_IDLE;
			odt_q <= 1'h0;
			dq_o_q <= '0;
			rd_hold_q <= '0;
		end else begin
			if (take) begin
				req_seen_q <= req_s2_q;
				cur_q <= hold_q;
				ca1_q <= hold_q.ca_first; // RULE_03
				ca2_q <= hold_q.ca_second; // RULE_03
				cs_q <= hold_q.rank_sel_n; // RULE_05
				odt_q <= hold_q.odt; // RULE_09
				dq_o_q <= hold_q.wdata; // RULE_01
			end else if (ck_q) begin
				cs_q <= RANKS_IDLE; // RULE_05
			end
			if (st_q == L_RD && (xing || rd_out)) begin
				rd_hold_q.timeout <= !xing;
				rd_hold_q.data <= dq_s2_q; // RULE_01 RULE_02
			end
		end
	end

	assign dq_o = dq_o_q;
	assign dq_oe_o = dq_oe_q;
	assign dqs_t_o = dqs_t_q;
	assign dqs_c_o = dqs_c_q;
	assign dqs_oe_o = dqs_oe_q;
	assign ca_first_o = ca1_q;
	assign ca_second_o = ca2_q;
	assign ck_t_o = {CK_W{ck_q}};
	assign ck_c_o = {CK_W{ckn_q}};
	assign cs_n_o = cs_q;
	assign cke_o = cke_q;
	assign odt_o = odt_q;

	property p_ck_diff;
		@(posedge link_clk_i) disable iff (!lrst_n)
		$past(lrst_n) |-> (ck_q != ckn_q) && (ck_q != $past(ck_q));
	endproperty
	a_ck_diff: assert property (p_ck_diff) // RULE_04
		else $error("memory clock pair not complementary");

	property p_ca_edge;
		@(posedge link_clk_i) disable iff (!lrst_n)
		$changed({ca1_q, ca2_q}) |-> !ck_q;
	endproperty
	a_ca_edge: assert property (p_ca_edge) // RULE_03
		else $error("cmd/addr changed away from clock fall");

	property p_cs_pulse;
		@(posedge link_clk_i) disable iff (!lrst_n)
		$fell(&cs_q) |-> !ck_q ##1 !(&cs_q) && ck_q ##1 (&cs_q);
	endproperty
	a_cs_pulse: assert property (p_cs_pulse) // RULE_05
		else $error("rank select not one memory clock long");

	property p_cke_pair;
		@(posedge link_clk_i) disable iff (!lrst_n)
		(cke_q[0] == cke_q[2]) && (cke_q[1] == cke_q[3]);
	endproperty
	a_cke_pair: assert property (p_cke_pair) // RULE_08
		else $error("clock enable pairs differ");

	property p_single;
		@(posedge link_clk_i) disable iff (!lrst_n)
		!dual_s2_q && !susp_s2_q |=>
			!cke_q[1] && !cke_q[3] && (cke_q[0] == $past(r0_on));
	endproperty
	a_single: assert property (p_single) // RULE_07
		else $error("single rank enables wrong");

	property p_susp;
		@(posedge link_clk_i) disable iff (!lrst_n)
		susp_s2_q |=> (cke_q == CKE_OFF);
	endproperty
	a_susp: assert property (p_susp) // RULE_06
		else $error("enables not low in suspend");

	property p_odt;
		@(posedge link_clk_i) disable iff (!lrst_n)
		$changed(odt_q) |-> ($past(st_q) == L_IDLE) && (odt_q == cur_q.odt);
	endproperty
	a_odt: assert property (p_odt) // RULE_09
		else $error("termination changed outside command take");

	property p_wr_drive;
		@(posedge link_clk_i) disable iff (!lrst_n)
		dq_oe_q |-> dqs_oe_q && (dq_o_q == cur_q.wdata) &&
			(st_q == L_WR0 || st_q == L_WR1);
	endproperty
	a_wr_drive: assert property (p_wr_drive) // RULE_10 RULE_01
		else $error("data driven outside a write");

	property p_rd_release;
		@(posedge link_clk_i) disable iff (!lrst_n)
		(st_q == L_RD) |-> !dq_oe_q && !dqs_oe_q;
	endproperty
	a_rd_release: assert property (p_rd_release) // RULE_10
		else $error("pins driven during a read");

	property p_wr_xing;
		@(posedge link_clk_i) disable iff (!lrst_n)
		(st_q == L_WR1) |-> (dqs_t_q == STRB_HI) && (dqs_c_q == STRB_LO);
	endproperty
	a_wr_xing: assert property (p_wr_xing) // RULE_02
		else $error("write strobe did not cross");

	property p_rd_bound;
		@(posedge link_clk_i) disable iff (!lrst_n)
		$rose(st_q == L_RD) |-> ##[1:17] (st_q == L_DONE);
	endproperty
	a_rd_bound: assert property (p_rd_bound) // RULE_02
		else $error("read did not finish in time");
endmodule

module lpchi_top (
	input wire logic MCLK_I, // core clock, 40 MHz
	input wire logic NRST_I, // async reset, low
	input wire logic LINK_CLK_I, // pin side clock
	input wire logic DUAL_RANK_I, // two ranks fitted
	input wire logic SUSPEND_TO_RAM_I, // self-refresh hold
	input wire lpchi_pkg::lpchi_cmd_t CHAN_A_CMD_I, // channel a command
	input wire logic CHAN_A_CMD_VALID_I, // channel a command valid
	output logic CHAN_A_CMD_READY_O, // channel a buffer room
	output lpchi_pkg::lpchi_rd_t CHAN_A_RD_O, // channel a read answer
	output logic CHAN_A_RD_VALID_O, // channel a answer pulse
	input wire logic [63:0] CHAN_A_DATA_BUS_I, // data in
	output logic [63:0] CHAN_A_DATA_BUS_O, // data out
	output logic CHAN_A_DATA_BUS_OE_O, // data drive
	input wire logic [7:0] CHAN_A_STROBE_TRUE_I, // strobe true in
	input wire logic [7:0] CHAN_A_STROBE_COMP_I, // strobe comp in
	output logic [7:0] CHAN_A_STROBE_TRUE_O, // strobe true out
	output logic [7:0] CHAN_A_STROBE_COMP_O, // strobe comp out
	output logic CHAN_A_STROBE_OE_O, // strobe drive
	output logic [9:0] CHAN_A_CMD_ADDR_FIRST_O, // cmd/addr first
	output logic [9:0] CHAN_A_CMD_ADDR_SECOND_O, // cmd/addr second
	output logic [1:0] CHAN_A_MEM_CLOCK_TRUE_O, // clock true
	output logic [1:0] CHAN_A_MEM_CLOCK_COMP_O, // clock comp
	output logic [1:0] CHAN_A_RANK_SELECT_N_O, // rank selects
	output logic [3:0] CHAN_A_CLOCK_ENABLES_O, // clock enables
	output logic CHAN_A_TERMINATION_CTRL_O, // termination
	input wire lpchi_pkg::lpchi_cmd_t CHAN_B_CMD_I, // channel b command
	input wire logic CHAN_B_CMD_VALID_I, // channel b command valid
	output logic CHAN_B_CMD_READY_O, // channel b buffer room
	output lpchi_pkg::lpchi_rd_t CHAN_B_RD_O, // channel b read answer
	output logic CHAN_B_RD_VALID_O, // channel b answer pulse
	input wire logic [63:0] CHAN_B_DATA_BUS_I, // data in
	output logic [63:0] CHAN_B_DATA_BUS_O, // data out
	output logic CHAN_B_DATA_BUS_OE_O, // data drive
	input wire logic [7:0] CHAN_B_STROBE_TRUE_I, // strobe true in
	input wire logic [7:0] CHAN_B_STROBE_COMP_I, // strobe comp in
	output logic [7:0] CHAN_B_STROBE_TRUE_O, // strobe true out
	output logic [7:0] CHAN_B_STROBE_COMP_O, // strobe comp out
	output logic CHAN_B_STROBE_OE_O, // strobe drive
	output logic [9:0] CHAN_B_CMD_ADDR_FIRST_O, // cmd/addr first
	output logic [9:0] CHAN_B_CMD_ADDR_SECOND_O, // cmd/addr second
	output logic [1:0] CHAN_B_MEM_CLOCK_TRUE_O, // clock true
	output logic [1:0] CHAN_B_MEM_CLOCK_COMP_O, // clock comp
	output logic [1:0] CHAN_B_RANK_SELECT_N_O, // rank selects
	output logic [3:0] CHAN_B_CLOCK_ENABLES_O, // clock enables
	output logic CHAN_B_TERMINATION_CTRL_O // termination
);
	import lpchi_pkg::*;

	// two independent channels, RULE_01
	lpchi_chan u_chan_a (
		.clk_i(MCLK_I),
		.rst_n_i(NRST_I),
		.link_clk_i(LINK_CLK_I),
		.dual_rank_i(DUAL_RANK_I),
		.suspend_to_ram_i(SUSPEND_TO_RAM_I),
		.cmd_i(CHAN_A_CMD_I),
		.cmd_valid_i(CHAN_A_CMD_VALID_I),
		.cmd_ready_o(CHAN_A_CMD_READY_O),
		.rd_o(CHAN_A_RD_O),
		.rd_valid_o(CHAN_A_RD_VALID_O),
		.dq_i(CHAN_A_DATA_BUS_I),
		.dq_o(CHAN_A_DATA_BUS_O),
		.dq_oe_o(CHAN_A_DATA_BUS_OE_O),
		.dqs_t_i(CHAN_A_STROBE_TRUE_I),
		.dqs_c_i(CHAN_A_STROBE_COMP_I),
		.dqs_t_o(CHAN_A_STROBE_TRUE_O),
		.dqs_c_o(CHAN_A_STROBE_COMP_O),
		.dqs_oe_o(CHAN_A_STROBE_OE_O),
		.ca_first_o(CHAN_A_CMD_ADDR_FIRST_O),
		.ca_second_o(CHAN_A_CMD_ADDR_SECOND_O),
		.ck_t_o(CHAN_A_MEM_CLOCK_TRUE_O),
		.ck_c_o(CHAN_A_MEM_CLOCK_COMP_O),
		.cs_n_o(CHAN_A_RANK_SELECT_N_O),
		.cke_o(CHAN_A_CLOCK_ENABLES_O),
		.odt_o(CHAN_A_TERMINATION_CTRL_O)
	);

	lpchi_chan u_chan_b (
		.clk_i(MCLK_I),
		.rst_n_i(NRST_I),
		.link_clk_i(LINK_CLK_I),
		.dual_rank_i(DUAL_RANK_I),
		.suspend_to_ram_i(SUSPEND_TO_RAM_I),
		.cmd_i(CHAN_B_CMD_I),
		.cmd_valid_i(CHAN_B_CMD_VALID_I),
		.cmd_ready_o(CHAN_B_CMD_READY_O),
		.rd_o(CHAN_B_RD_O),
		.rd_valid_o(CHAN_B_RD_VALID_O),
		.dq_i(CHAN_B_DATA_BUS_I),
		.dq_o(CHAN_B_DATA_BUS_O),
		.dq_oe_o(CHAN_B_DATA_BUS_OE_O),
		.dqs_t_i(CHAN_B_STROBE_TRUE_I),
		.dqs_c_i(CHAN_B_STROBE_COMP_I),
		.dqs_t_o(CHAN_B_STROBE_TRUE_O),
		.dqs_c_o(CHAN_B_STROBE_COMP_O),
		.dqs_oe_o(CHAN_B_STROBE_OE_O),
		.ca_first_o(CHAN_B_CMD_ADDR_FIRST_O),
		.ca_second_o(CHAN_B_CMD_ADDR_SECOND_O),
		.ck_t_o(CHAN_B_MEM_CLOCK_TRUE_O),
		.ck_c_o(CHAN_B_MEM_CLOCK_COMP_O),
		.cs_n_o(CHAN_B_RANK_SELECT_N_O),
		.cke_o(CHAN_B_CLOCK_ENABLES_O),
		.odt_o(CHAN_B_TERMINATION_CTRL_O)
	);
endmodule

// *** sim/lpchi_sdram_model.sv ***
// Purpose: behavioural soldered sdram pair seen from one channel's pins
// Assumes: a select with no write drive after it is a read
// Notes: dly_i sets the read latency in link cycles; released lines invert
`timescale 1ns/1ps
module lpchi_sdram_model (
	input wire logic link_clk_i, // pin side clock
	input wire logic [1:0] cs_n_i, // rank selects, low
	input wire logic dq_oe_i, // controller drives data
	input wire logic [63:0] dq_i, // controller data
	input wire logic [7:0] dqs_t_i, // controller strobe true
	input wire logic [7:0] dly_i, // read latency
	output logic [63:0] dq_o, // data back
	output logic [7:0] dqs_t_o, // strobe true back
	output logic [7:0] dqs_c_o // strobe comp back
);
	logic [63:0] mem_q = 64'h0;
	logic [7:0] cnt_q = 8'h0;
	logic busy_q = 1'b0;
	logic drv;
	// drive only inside the read burst window
	assign drv = busy_q && cnt_q >= 8'h6 + dly_i && cnt_q < 8'ha + dly_i;
	assign dq_o = drv ? mem_q : ~mem_q;
	assign dqs_t_o = drv ? 8'hff : 8'h00;
	assign dqs_c_o = ~dqs_t_o;
	always_ff @(posedge link_clk_i) begin
		if (dq_oe_i && dqs_t_i == 8'hff)
			mem_q <= dq_i;
		if (busy_q && (dq_oe_i || cnt_q == 8'ha + dly_i))
			busy_q <= 1'b0;
		else if (!busy_q && cs_n_i != 2'h3 && !dq_oe_i)
			busy_q <= 1'b1;
		cnt_q <= busy_q ? cnt_q + 8'h1 : 8'h0;
	end
endmodule

// *** sim/test_lpchi_top.sv ***
// Purpose: self-checking bench for both memory channels
// Assumes: one sdram model per channel, 12 ns link clock
// Notes: pins are resolved from the controller's drive enables only
`timescale 1ns/1ps
module test_lpchi_top;
	import lpchi_pkg::*;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic nrst = 1'b0;
	logic dual = 1'b1;
	logic susp = 1'b0;
	lpchi_cmd_t cmd[2] = '{default: '0};
	logic vld[2] = '{1'b0, 1'b0};
	logic [7:0] dly[2] = '{8'h2, 8'h2};
	logic [63:0] wdat[2];
	wire lpchi_rd_t rd[2];
	wire rdy[2], rdv[2], doe[2], soe[2], odt[2];
	wire [63:0] dqo[2], dqi[2], mdq[2];
	wire [7:0] sto[2], sco[2], sti[2], sci[2], mst[2], msc[2];
	wire [9:0] ca1[2], ca2[2];
	wire [1:0] ckt[2], ckc[2], csn[2];
	wire [3:0] cke[2];
	int fails = 0;
	int checks_done = 0;
	logic [1:0] seen_cs[2];
	logic [9:0] seen_ca1[2], seen_ca2[2];
	logic oe_seen[2];

	initial forever #12.5 clk = ~clk;
	initial begin
		#3;
		forever #6 lclk = ~lclk;
	end

	lpchi_top i_lpchi_top (.MCLK_I(clk), .NRST_I(nrst), .LINK_CLK_I(lclk),
		.DUAL_RANK_I(dual), .SUSPEND_TO_RAM_I(susp),
		.CHAN_A_CMD_I(cmd[0]), .CHAN_A_CMD_VALID_I(vld[0]),
		.CHAN_A_CMD_READY_O(rdy[0]), .CHAN_A_RD_O(rd[0]),
		.CHAN_A_RD_VALID_O(rdv[0]), .CHAN_A_DATA_BUS_I(dqi[0]),
		.CHAN_A_DATA_BUS_O(dqo[0]), .CHAN_A_DATA_BUS_OE_O(doe[0]),
		.CHAN_A_STROBE_TRUE_I(sti[0]), .CHAN_A_STROBE_COMP_I(sci[0]),
		.CHAN_A_STROBE_TRUE_O(sto[0]), .CHAN_A_STROBE_COMP_O(sco[0]),
		.CHAN_A_STROBE_OE_O(soe[0]), .CHAN_A_CMD_ADDR_FIRST_O(ca1[0]),
		.CHAN_A_CMD_ADDR_SECOND_O(ca2[0]), .CHAN_A_MEM_CLOCK_TRUE_O(ckt[0]),
		.CHAN_A_MEM_CLOCK_COMP_O(ckc[0]), .CHAN_A_RANK_SELECT_N_O(csn[0]),
		.CHAN_A_CLOCK_ENABLES_O(cke[0]), .CHAN_A_TERMINATION_CTRL_O(odt[0]),
		.CHAN_B_CMD_I(cmd[1]), .CHAN_B_CMD_VALID_I(vld[1]),
		.CHAN_B_CMD_READY_O(rdy[1]), .CHAN_B_RD_O(rd[1]),
		.CHAN_B_RD_VALID_O(rdv[1]), .CHAN_B_DATA_BUS_I(dqi[1]),
		.CHAN_B_DATA_BUS_O(dqo[1]), .CHAN_B_DATA_BUS_OE_O(doe[1]),
		.CHAN_B_STROBE_TRUE_I(sti[1]), .CHAN_B_STROBE_COMP_I(sci[1]),
		.CHAN_B_STROBE_TRUE_O(sto[1]), .CHAN_B_STROBE_COMP_O(sco[1]),
		.CHAN_B_STROBE_OE_O(soe[1]), .CHAN_B_CMD_ADDR_FIRST_O(ca1[1]),
		.CHAN_B_CMD_ADDR_SECOND_O(ca2[1]), .CHAN_B_MEM_CLOCK_TRUE_O(ckt[1]),
		.CHAN_B_MEM_CLOCK_COMP_O(ckc[1]), .CHAN_B_RANK_SELECT_N_O(csn[1]),
		.CHAN_B_CLOCK_ENABLES_O(cke[1]), .CHAN_B_TERMINATION_CTRL_O(odt[1]));

	for (genvar g = 0; g < 2; g++) begin : g_ch
		assign dqi[g] = doe[g] ? dqo[g] : mdq[g];
		assign sti[g] = soe[g] ? sto[g] : mst[g];
		assign sci[g] = soe[g] ? sco[g] : msc[g];
		lpchi_sdram_model i_lpchi_sdram_model (.link_clk_i(lclk),
			.cs_n_i(csn[g]), .dq_oe_i(doe[g]), .dq_i(dqo[g]),
			.dqs_t_i(sto[g]), .dly_i(dly[g]), .dq_o(mdq[g]),
			.dqs_t_o(mst[g]), .dqs_c_o(msc[g]));
		// record pins away from the edge that launches them
		always @(negedge lclk) begin
			chk_pin({8'h0, ckc[g] ^ ckt[g]}, 10'h3);
			if (csn[g] != 2'h3) begin
				seen_cs[g] <= csn[g];
				seen_ca1[g] <= ca1[g];
				seen_ca2[g] <= ca2[g];
			end
			if (doe[g])
				oe_seen[g] <= 1'b1;
		end
	end

	task automatic chk_pin(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t pin got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_data(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t data got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// NOP selects no rank; odd addresses pick rank 1
	task automatic send(input int c, input lpchi_op_t op,
		input logic [9:0] a, input logic [63:0] d, input logic [1:0] k);
		@(negedge clk);
		cmd[c] = '{op, (op == OP_NOP) ? 2'h3 : (a[0] ? 2'h1 : 2'h2),
			a, ~a, k, a[1], d};
		vld[c] = 1'b1;
		oe_seen[c] = 1'b0;
		while (!rdy[c])
			@(negedge clk);
		@(posedge clk);
	endtask

	task automatic idle(input int c);
		@(negedge clk);
		vld[c] = 1'b0;
	endtask

	task automatic wait_rd(input int c, input logic [63:0] d, input logic to);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (rdv[c] !== 1'b1 && n < 300);
		chk_pin({9'h0, rdv[c]}, 10'h1);
		chk_pin({9'h0, rd[c].timeout}, {9'h0, to});
		if (!to)
			chk_data(rd[c].data, d);
	endtask

	task automatic wait_cke(input int c, input logic [3:0] e);
		int n;
		for (n = 0; n < 60 && cke[c] !== e; n++)
			@(negedge clk);
		chk_pin({6'h0, cke[c]}, {6'h0, e});
	endtask

	task automatic t_reset;
		for (int c = 0; c < 2; c++) begin
			chk_pin({rdy[c], rdv[c], doe[c], soe[c], odt[c], csn[c], ckt[c],
				1'b0}, 10'h218);
			chk_pin({4'h0, cke[c], ckc[c]}, 10'h3);
			chk_data({48'h0, sto[c], sco[c]}, 64'hff);
		end
		$display("reset values done");
	endtask

	task automatic t_wr_rd(input int c, input logic [9:0] a,
		input logic [63:0] d);
		int n;
		wdat[c] = d;
		send(c, OP_WRITE, a, d, 2'h3);
		idle(c);
		for (n = 0; n < 200 && !(oe_seen[c] && !doe[c]); n++)
			@(negedge clk);
		chk_pin({9'h0, oe_seen[c]}, 10'h1);
		chk_pin(seen_ca1[c], a);
		chk_pin(seen_ca2[c], ~a);
		chk_pin({8'h0, seen_cs[c]}, a[0] ? 10'h1 : 10'h2);
		chk_pin({9'h0, odt[c]}, {9'h0, a[1]});
		send(c, OP_READ, ~a, 64'h0, 2'h3);
		idle(c);
		wait_rd(c, d, 1'b0);
		chk_pin({9'h0, oe_seen[c]}, 10'h0);
		chk_pin(seen_ca1[c], ~a);
		$display("write read channel %0d done", c);
	endtask

	task automatic t_buf(input int c);
		dly[c] = 8'h6;
		for (int i = 0; i < 3; i++)
			send(c, OP_READ, 10'(i), 64'h0, 2'h3);
		idle(c);
		chk_pin({9'h0, rdy[c]}, 10'h0);
		// first answer frees a slot; catch it before refilling
		wait_rd(c, wdat[c], 1'b0);
		send(c, OP_READ, 10'h3, 64'h0, 2'h3);
		idle(c);
		for (int i = 0; i < 3; i++)
			wait_rd(c, wdat[c], 1'b0);
		chk_pin({9'h0, rdy[c]}, 10'h1);
		dly[c] = 8'h2;
		$display("buffer channel %0d done", c);
	endtask

	task automatic t_timeout;
		dly[0] = 8'h28;
		send(0, OP_READ, 10'h2, 64'h0, 2'h3);
		idle(0);
		wait_rd(0, 64'h0, 1'b1);
		repeat (40) @(negedge clk);
		dly[0] = 8'h2;
		$display("read timeout done");
	endtask

	task automatic t_rank;
		logic [1:0] k;
		for (int r = 0; r < 2; r++) begin
			for (int j = 1; j < 4; j++) begin
				k = 2'(j);
				dual = r[0];
				for (int c = 0; c < 2; c++) begin
					send(c, OP_NOP, 10'h0, 64'h0, k);
					idle(c);
				end
				for (int c = 0; c < 2; c++)
					wait_cke(c, r ? {k, k} : {1'b0, k[0], 1'b0, k[0]});
			end
		end
		$display("rank enables done");
	endtask

	task automatic t_susp;
		susp = 1'b1;
		for (int c = 0; c < 2; c++)
			wait_cke(c, 4'h0);
		@(negedge clk);
		susp = 1'b0;
		for (int c = 0; c < 2; c++)
			wait_cke(c, 4'hf);
		$display("suspend done");
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("BAD %0t watchdog expired", $time);
		end_sim;
	end

	initial begin
		repeat (6) @(negedge clk);
		t_reset;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_wr_rd(0, 10'h2a5, 64'h0123456789abcdef);
		t_wr_rd(1, 10'h15a, 64'hfedcba9876543210);
		t_buf(1);
		t_timeout;
		t_rank;
		t_susp;
		end_sim;
	end
endmodule
